// ===== verilog/ppf_pin_select.sv
// Purpose: Per-pin mode, direction and alternative function routing
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   Pad signals and peripheral bundles are 16 bits, one per pin
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module ppf_pin_select
  import ppf_pkg::*;
#(
  parameter bit DEBUG_GROUP = 1'b0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port data and peripheral side
  input  wire logic        debug_active,
  input  wire logic [15:0] port_out,
  input  wire logic [15:0] alt_out_data [4],
  input  wire logic [15:0] alt_dir_in [4],
  output logic      [15:0] alt_in_data [4],
  output logic      [15:0] alt_in_valid [4],
  output logic      [15:0] port_in,
  // Pad side
  input  wire logic [15:0] pad_in,
  output ppf_pad_t         pad
);

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        wr_fire;
  logic        wr_known;

  // Address and data taken in either order; no new ones until response
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign wr_fire       = aw_held && w_held && !bvalid;
  assign wr_known      = aw_addr inside {OFS_DIR, OFS_FUNC, OFS_DIRECT,
                           OFS_IBUF, OFS_ALT_LOW, OFS_ALT_HIGH, OFS_DIR_MSR,
                           OFS_FUNC_MSR}; // Status is read only

  // Write channel bookkeeping
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  ppf_cfg_t    cfg;
  logic [31:0] wd_masked;

  // Unstrobed bytes of a masked write count as zero: no mask, no change
  always_comb begin
    wd_masked = w_data;
    for (int b = 0; b < 4; b++) begin
      if (!w_strb[b]) begin
        wd_masked[b*8 +: 8] = 8'h00;
      end
    end
  end

  ppf_mask_reg #(.RESET_VALUE(RST_DIR)) u_dir (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .whole_we  (wr_fire && aw_addr == OFS_DIR && w_strb[1:0] == 2'h3),
    .masked_we (wr_fire && aw_addr == OFS_DIR_MSR),
    .wdata     (aw_addr == OFS_DIR_MSR ? wd_masked : w_data),
    .value     (cfg.dir)
  );

  ppf_mask_reg #(.RESET_VALUE(RST_FUNC)) u_func (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .whole_we  (wr_fire && aw_addr == OFS_FUNC && w_strb[1:0] == 2'h3),
    .masked_we (wr_fire && aw_addr == OFS_FUNC_MSR),
    .wdata     (aw_addr == OFS_FUNC_MSR ? wd_masked : w_data),
    .value     (cfg.func)
  );

  logic [15:0] next_direct;
  logic [15:0] next_ibuf;
  logic [15:0] next_alt_low;
  logic [15:0] next_alt_high;

  // Plain registers; both low byte strobes (wstrb 1:0) are needed to update them
  always_comb begin
    next_direct   = cfg.direct;
    next_ibuf     = cfg.ibuf;
    next_alt_low  = cfg.alt_low;
    next_alt_high = cfg.alt_high;
    if (wr_fire && w_strb[1:0] == 2'h3) begin
      case (aw_addr)
        OFS_DIRECT:   next_direct   = w_data[15:0];
        OFS_IBUF:     next_ibuf     = w_data[15:0];
        OFS_ALT_LOW:  next_alt_low  = w_data[15:0];
        OFS_ALT_HIGH: next_alt_high = w_data[15:0];
        default:      next_direct   = cfg.direct;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.direct   <= RST_DIRECT;
      cfg.ibuf     <= RST_IBUF;
      cfg.alt_low  <= RST_ALT;
      cfg.alt_high <= RST_ALT;
    end else begin
      cfg.direct   <= next_direct;
      cfg.ibuf     <= next_ibuf;
      cfg.alt_low  <= next_alt_low;
      cfg.alt_high <= next_alt_high;
    end
  end

  // ****************************************************************
  // Per-pin routing
  // ****************************************************************
  logic        withheld;
  logic [15:0] pin_is_out;
  logic [15:0] pad_out_c;
  logic [15:0] pad_ie_c;

  // Debug group gives its pins up while a session runs
  assign withheld = DEBUG_GROUP && debug_active;

  for (genvar m = 0; m < NPINS; m++) begin : g_pin
    logic [1:0] sel;
    logic [3:0] hit;
    assign sel = {cfg.alt_high[m], cfg.alt_low[m]};
    always_comb begin
      pin_is_out[m] = !cfg.dir[m];
      pad_out_c[m]  = port_out[m];
      hit           = 4'h0;
      if (cfg.func[m]) begin
        if (cfg.direct[m]) begin
          pin_is_out[m] = alt_dir_in[sel][m];
        end
        pad_out_c[m] = alt_out_data[sel][m];
        hit[sel]     = !pin_is_out[m];
      end
      // Port input needs software's buffer enable; alt input on whenever the pin is an input
      pad_ie_c[m] = !pin_is_out[m] && (cfg.func[m] || cfg.ibuf[m]);
      if (withheld) begin
        hit           = 4'h0;
        pin_is_out[m] = 1'b0;
        pad_ie_c[m]   = 1'b0;
      end
    end
    // Each bit has one driver; every function sees the pad level
    for (genvar f = 0; f < 4; f++) begin : g_fn
      assign alt_in_data[f][m]  = pad_in[m];
      assign alt_in_valid[f][m] = hit[f];
    end
  end

  // Pad drive is registered so data outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad     <= '0;
      port_in <= 16'h0000;
    end else begin
      pad.out <= pad_out_c;
      pad.oe  <= pin_is_out;
      pad.ie  <= pad_ie_c;
      port_in <= pad_in & pad_ie_c & ~cfg.func;
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // Masked registers read zero; status shows live direction
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_DIR:      next_rdata = {16'h0000, cfg.dir};
        OFS_FUNC:     next_rdata = {16'h0000, cfg.func};
        OFS_DIRECT:   next_rdata = {16'h0000, cfg.direct};
        OFS_IBUF:     next_rdata = {16'h0000, cfg.ibuf};
        OFS_ALT_LOW:  next_rdata = {16'h0000, cfg.alt_low};
        OFS_ALT_HIGH: next_rdata = {16'h0000, cfg.alt_high};
        OFS_DIR_MSR,
        OFS_FUNC_MSR: next_rdata = 32'h00000000;
        OFS_STATUS:   next_rdata = {16'h0000, pad.oe};
        default: {next_rdata, next_rresp} = {32'h00000000, RESP_SLVERR};
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_port_dir_follows : assert property (@(posedge aclk) disable iff (!aresetn)
    !withheld && !cfg.func[0] |=> pad.oe[0] == !$past(cfg.dir[0]))
    else $error("port mode direction wrong");

  a_sw_alt_dir : assert property (@(posedge aclk) disable iff (!aresetn)
    !withheld && cfg.func[1] && !cfg.direct[1]
      |=> pad.oe[1] == !$past(cfg.dir[1]))
    else $error("software alt direction wrong");

  a_direct_alt_dir : assert property (@(posedge aclk) disable iff (!aresetn)
    !withheld && cfg.func[2] && cfg.direct[2]
      |=> pad.oe[2] == $past(alt_dir_in[{cfg.alt_high[2],cfg.alt_low[2]}][2]))
    else $error("direct alt direction wrong");

  a_alt_out_route : assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.func[3] |=> pad.out[3] ==
      $past(alt_out_data[{cfg.alt_high[3],cfg.alt_low[3]}][3]))
    else $error("alt output routed wrongly");

  a_alt_in_one : assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.func[4] && !cfg.direct[4] && cfg.dir[4] && !withheld
      |-> alt_in_valid[{cfg.alt_high[4],cfg.alt_low[4]}][4])
    else $error("alt input not selected");

  a_debug_release : assert property (@(posedge aclk) disable iff (!aresetn)
    withheld [*2] |-> pad.oe == 16'h0000)
    else $error("debug group still driven");

  a_write_resp : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid)
    else $error("write response missing");

  a_func_whole : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && aw_addr == OFS_FUNC && w_strb[1:0] == 2'h3
      |=> cfg.func == $past(w_data[15:0]))
    else $error("whole write to function lost");

endmodule : ppf_pin_select

// ===== verilog/ppf_pkg.sv
// Purpose: Constants and types for the port pin function select block
// Assumes: 16 pins per port group, AXI4-Lite register access
// Notes:   Offsets and reset values live here only
//
// Notes on behaviour
// - Function bit 0: general port, direction bit
// - Software alt mode: software direction, 0 out
// - Direct alt mode: peripheral drives the direction
// - Software alt: output alt if 0, input if 1
// - High/low select pair picks function one-four
// - Direction masked write copies bits under upper mask
// - Function masked write copies bits under upper mask
// - Whole and masked writes both accepted, mixed
// - Debug group pins withheld during debug session
// - Every pin has its own settings
package ppf_pkg;

  localparam int unsigned NPINS = 16;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_DIR      = 8'h00;
  localparam logic [7:0] OFS_FUNC     = 8'h04;
  localparam logic [7:0] OFS_DIRECT   = 8'h08;
  localparam logic [7:0] OFS_IBUF     = 8'h0C;
  localparam logic [7:0] OFS_ALT_LOW  = 8'h10;
  localparam logic [7:0] OFS_ALT_HIGH = 8'h14;
  localparam logic [7:0] OFS_DIR_MSR  = 8'h18;
  localparam logic [7:0] OFS_FUNC_MSR = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [15:0] RST_DIR    = 16'hFFFF; // Pins come up as inputs
  localparam logic [15:0] RST_FUNC   = 16'h0000;
  localparam logic [15:0] RST_DIRECT = 16'h0000;
  localparam logic [15:0] RST_IBUF   = 16'h0000;
  localparam logic [15:0] RST_ALT    = 16'h0000;
  localparam int unsigned MASK_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-pin configuration as stored
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] func;
    logic [15:0] direct;
    logic [15:0] ibuf;
    logic [15:0] alt_low;
    logic [15:0] alt_high;
  } ppf_cfg_t;

  // Pad drive bundle
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] ie;
  } ppf_pad_t;

endpackage : ppf_pkg

// ===== verilog/ppf_mask_reg.sv
// Purpose: One 16-bit config register with whole and masked write
// Assumes: At most one whole and one masked write per cycle
// Notes:   Masked write applied after whole write, so it wins
`timescale 1ns/1ps
module ppf_mask_reg
  import ppf_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        whole_we,
  input  wire logic        masked_we,
  input  wire logic [31:0] wdata,
  output logic      [15:0] value
);

  logic [15:0] next_value;

  // Whole write first, then masked bits on top
  always_comb begin
    next_value = value;
    if (whole_we) begin
      next_value = wdata[15:0];
    end
    if (masked_we) begin
      next_value = (next_value & ~wdata[31:MASK_LSB])
                 | (wdata[15:0] & wdata[31:MASK_LSB]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

  a_masked_keeps_bits : assert property (@(posedge aclk) disable iff (!aresetn)
    masked_we && !whole_we |=> ((value ^ $past(value)) & ~$past(wdata[31:16]))
      == 16'h0000)
    else $error("masked write disturbed unmasked bit");

  a_masked_sets_bits : assert property (@(posedge aclk) disable iff (!aresetn)
    masked_we |=> ((value ^ $past(wdata[15:0])) & $past(wdata[31:16]))
      == 16'h0000)
    else $error("masked write did not copy bit");

endmodule : ppf_mask_reg

// ===== sim/ppf_periph_model.sv
// Purpose: Peripheral and pad stand-in for the pin select bench
// Assumes: Function outputs change only when the bench asks
// Notes:   Undriven pads follow the bench's external level
`timescale 1ns/1ps
module ppf_periph_model
  import ppf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        step,
  input  wire logic [15:0] ext,
  input  wire ppf_pad_t    pad,
  output logic      [15:0] alt_out_data [4],
  output logic      [15:0] alt_dir_in [4],
  output logic      [15:0] pad_in
);
  // ****************************************************************
  // Function outputs and pad level
  // ****************************************************************
  // Held steady between steps so the bench can predict the pads
  initial begin
    alt_out_data = '{default: 16'h0000};
    alt_dir_in   = '{default: 16'h0000};
  end
  always @(posedge aclk) begin
    if (step) begin
      for (int f = 0; f < 4; f++) begin
        alt_out_data[f] <= 16'($urandom);
        alt_dir_in[f]   <= 16'($urandom);
      end
    end
  end
  // A pin the block drives reads back its own level
  always_comb begin
    for (int m = 0; m < 16; m++) begin
      pad_in[m] = (pad.oe[m] === 1'h1) ? pad.out[m] : ext[m];
    end
  end
endmodule : ppf_periph_model

// ===== sim/tb.sv
// Purpose: Self-checking bench for the pin function select block
// Assumes: Config registers read back in bits 15:0, upper bits zero
// Notes:   Bus answers are checked from a queue of expected results
`timescale 1ns/1ps
module tb import ppf_pkg::*;;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic        dbg = 1'h0, step = 1'h0;
  logic [3:0]  ws = 4'hF;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic        awr, wr, bv, arr, rv;
  logic [1:0]  br, rr;
  logic [15:0] pout = 16'h0000, ext = 16'h0000, pin_q, pad_in, e_oe;
  logic [15:0] aod [4], adi [4], aid [4], aiv [4], mreg [6];
  ppf_pad_t    pad;
  logic [33:0] exp_q [$], e;
  int          n_mismatch = 0, n_checks = 0, it;
  logic [7:0]  ofs [6] = '{OFS_DIR, OFS_FUNC, OFS_DIRECT, OFS_IBUF,
                           OFS_ALT_LOW, OFS_ALT_HIGH};

  always #12.5 aclk = ~aclk;

  // Debug group instance so withholding can be seen; wstrb mostly full
  ppf_pin_select #(.DEBUG_GROUP(1'h1)) ppf_pin_select_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .debug_active(dbg), .port_out(pout),
    .alt_out_data(aod), .alt_dir_in(adi), .alt_in_data(aid),
    .alt_in_valid(aiv), .port_in(pin_q), .pad_in(pad_in), .pad(pad));

  ppf_periph_model ppf_periph_model_i (
    .aclk(aclk), .step(step), .ext(ext), .pad(pad),
    .alt_out_data(aod), .alt_dir_in(adi), .pad_in(pad_in));

  // Each bus answer takes the oldest expected note
  always @(posedge aclk) begin
    if ((bv & bre) === 1'h1 || (rv & rre) === 1'h1) begin
      e = '1;
      if (exp_q.size() > 0) e = exp_q.pop_front();
      check({30'h0, bv ? br : rr}, {30'h0, e[33:32]});
      if (bv !== 1'h1) check(rd, e[31:0]);
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr === 1'h1) awv <= 1'h0;
      if (wr === 1'h1) wv <= 1'h0;
    end while (bv !== 1'h1);
    bre <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr === 1'h1) arv <= 1'h0;
    end while (rv !== 1'h1);
    rre <= 1'h0;
  endtask : axi_rd

  task automatic reg_wr(input int i, input logic [15:0] v);
    mreg[i] = v;
    axi_wr(ofs[i], {16'h0000, v}, RESP_OKAY);
  endtask : reg_wr

  // Masked writes touch only bits whose upper mask bit is set
  task automatic msk_wr(input int i, input logic [15:0] k,
                        input logic [15:0] v);
    mreg[i] = (mreg[i] & ~k) | (v & k);
    axi_wr(i ? OFS_FUNC_MSR : OFS_DIR_MSR, {k, v}, RESP_OKAY);
  endtask : msk_wr

  task automatic readback;
    for (int i = 0; i < 6; i++) axi_rd(ofs[i], {16'h0, mreg[i]}, RESP_OKAY);
  endtask : readback

  // Pad and routing prediction from the mirrored settings, pin by pin
  task automatic check_pins;
    logic [15:0] oe, ie, ou, iv [4];
    logic [1:0]  s;
    iv = '{default: 16'h0000};
    for (int m = 0; m < 16; m++) begin
      s = {mreg[5][m], mreg[4][m]};
      ou[m] = mreg[1][m] ? aod[s][m] : pout[m];
      if (!mreg[1][m]) begin
        oe[m] = ~mreg[0][m];
        ie[m] = mreg[0][m] & mreg[3][m];
      end else if (!mreg[2][m]) begin
        oe[m] = ~mreg[0][m];
        iv[s][m] = mreg[0][m];
      end else begin
        oe[m] = adi[s][m];
        iv[s][m] = ~adi[s][m];
      end
      if (mreg[1][m]) ie[m] = ~oe[m];
      if (dbg) begin
        oe[m] = 1'h0;
        ie[m] = 1'h0;
        iv[s][m] = 1'h0;
      end
    end
    e_oe = oe;
    check(pad.oe, oe);
    check(pad.ie, ie);
    check(pad.out & oe, ou & oe);
    for (int f = 0; f < 4; f++) begin
      check(aiv[f], iv[f]);
      check(aid[f], pad_in);
    end
    check(pin_q, dbg ? 16'h0000 : pad_in & ~mreg[1] & mreg[0] & mreg[3]);
  endtask : check_pins

  // ****************************************************************
  // Tests
  // ****************************************************************
  // Reset values, refused accesses, then random configurations
  initial begin
    void'($urandom(54));
    mreg = '{RST_DIR, RST_FUNC, RST_DIRECT, RST_IBUF, RST_ALT, RST_ALT};
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    readback;
    axi_rd(8'h24, 32'h0, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
    // Low half-word unstrobed: plain write ignored; mask lanes unstrobed
    ws <= 4'hC;
    axi_wr(OFS_DIRECT, 32'h0000_FFFF, RESP_OKAY);
    ws <= 4'h3;
    axi_wr(OFS_FUNC_MSR, 32'hFFFF_FFFF, RESP_OKAY);
    ws <= 4'hF;
    readback;
    for (it = 0; it < 24; it++) begin
      dbg <= (it % 4 == 3);
      pout <= 16'($urandom);
      ext <= 16'($urandom);
      step <= 1'h1;
      @(posedge aclk);
      step <= 1'h0;
      for (int i = 0; i < 6; i++) reg_wr(i, 16'($urandom));
      // Enable the input buffer on every port-mode input pin
      reg_wr(3, mreg[3] | (mreg[0] & ~mreg[1]));
      repeat (3) @(posedge aclk);
      check_pins;
      axi_rd(OFS_STATUS, {16'h0000, e_oe}, RESP_OKAY);
      msk_wr(it % 2, it == 1 ? 16'hFFFF : it == 2 ? 16'h0000 :
             16'($urandom), 16'($urandom));
      readback;
      repeat (3) @(posedge aclk);
      check_pins;
    end
    report_and_stop;
  end

  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop;
  end
endmodule : tb
